/* design/mcs_clock_switch.v */
// Summary of operation
// [R1] Software splits source and prescaler changes into two separate writes.
// [R2] Moving to a synth: prescaler first, wait ready, then source.
// [R3] Moving to main or slow: source first, wait ready, then prescaler.
// [R4] Ready flag drops on source or prescaler change, rises once stable.
// [R5] Software waits for ready before using master clock.
// [R6] Ready flag rising can raise the interrupt when enabled.
// [R7] Rewriting selected synth config drops ready until lock returns.
// [R8] Unlocked first synth falls back to slow, second to main.
// [R9] Three programmable outputs with write-one enable, disable, state.
// [R10] All programmable outputs disabled after reset.
// [R11] Programmable source: main, slow, master, either synth; slow default.
// [R12] Programmable output is source divided by 1 to 64, powers of two.
// [R13] Prescaler resets to zero, output equals slow clock.
// [R14] Enabled programmable clock sets ready flag, optional interrupt.
// [R15] Whole programmable config accepted in one write.
// [R16] Software disables output before changing its source or prescaler.
// [R17] Synth lock flag set after programmed count of slow clock edges.
// [R18] Disable clears ready and holds output low.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_consts.vh"

module mcs_clock_switch (
    input wire core_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire slow_clk_lvl,
    input wire main_clk_lvl,
    input wire first_synth_output,
    input wire second_synth_output,
    output reg master_clk_out,
    output wire [2:0] prog_clock_out,
    output reg irq
);

    function div_tap;
        input lvl;
        input [5:0] cnt;
        input [2:0] p;
        begin
            case (p)
                3'h0: div_tap = lvl;
                3'h1: div_tap = cnt[0];
                3'h2: div_tap = cnt[1];
                3'h3: div_tap = cnt[2];
                3'h4: div_tap = cnt[3];
                3'h5: div_tap = cnt[4];
                default: div_tap = cnt[5];
            endcase
        end
    endfunction

    reg [1:0] css_ff;
    reg [2:0] clock_divider_select_ff;
    reg mck_rdy_ff;
    reg [3:0] mck_cnt_ff;
    reg [5:0] mck_div_ff;
    reg [4:0] src_prev_ff;
    reg [31:0] st_prev_ff;
    reg [31:0] irq_sts_ff;
    reg [31:0] irq_en_ff;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg [2:0] mck_idx;
    reg [31:0] nxt_irq_sts;
    reg [31:0] nxt_irq_en;
    reg [2:0] mck_st_ff;
    reg [2:0] nxt_mck_st;
    reg [3:0] nxt_mck_cnt;
    reg nxt_mck_rdy;

    // Master ready sequencer, one-hot
    localparam [2:0] st_ready = 3'b001;
    localparam [2:0] st_settle = 3'b010;
    localparam [2:0] st_relock = 3'b100;

    wire [1:0] lock_w;
    wire [27:0] syn_cfg_w;
    wire [2:0] pck_en_w;
    wire [2:0] pck_rdy_w;
    wire [17:0] pck_cfg_w;
    wire [4:0] src_lvl;
    wire [4:0] src_rise;
    wire acc_first;
    wire wr_acc;
    wire [31:0] status_w;
    wire [31:0] events_w;
    wire mck_wr;
    wire mck_change;
    wire syn_unlocked;

    assign src_lvl = {second_synth_output, first_synth_output,
                      master_clk_out, main_clk_lvl, slow_clk_lvl};
    assign src_rise = src_lvl & ~src_prev_ff;
    assign acc_first = psel & penable & ~pready;
    assign wr_acc = psel & penable & pready & pwrite;

    assign status_w = {21'h000000, pck_rdy_w, 4'h0, mck_rdy_ff,
                       lock_w, 1'b0};
    // Sticky events come from rising edges of the status flags
    assign events_w = status_w & ~st_prev_ff & `MCS_IRQ_BITS;

    // Device does not police split writes; it just reacts to each one
    // [R1] per-write compare
    assign mck_wr = wr_acc & (paddr == `MCS_OFF_MCKCFG);
    assign mck_change = mck_wr &
        ((pwdata[`MCS_CSS_MSB:`MCS_CSS_LSB] != css_ff) |
         (pwdata[`MCS_CLOCK_DIVIDER_SELECT_MSB:`MCS_CLOCK_DIVIDER_SELECT_LSB] != clock_divider_select_ff));
    assign syn_unlocked = ((css_ff == `MCS_SRC_SYNA) & ~lock_w[0]) |
                          ((css_ff == `MCS_SRC_SYNB) & ~lock_w[1]);

    // [R8] fallback source choice
    always @* begin
        case (css_ff)
            `MCS_SRC_MAIN: mck_idx = `MCS_PSRC_MAIN;
            `MCS_SRC_SYNA: mck_idx = lock_w[0] ? `MCS_PSRC_SYNA
                                               : `MCS_PSRC_SLOW;
            `MCS_SRC_SYNB: mck_idx = lock_w[1] ? `MCS_PSRC_SYNB
                                               : `MCS_PSRC_MAIN;
            default: mck_idx = `MCS_PSRC_SLOW;
        endcase
    end

    // [R4] drop ready then settle
    // [R7] relock holds ready low
    always @* begin
        nxt_mck_st = mck_st_ff;
        nxt_mck_cnt = mck_cnt_ff;
        nxt_mck_rdy = mck_rdy_ff;
        if (mck_change | syn_unlocked) begin
            // A change in mid-settle restarts the whole wait
            nxt_mck_st = syn_unlocked ? st_relock : st_settle;
            nxt_mck_cnt = `MCS_MCK_SETTLE;
            nxt_mck_rdy = 1'b0;
        end else begin
            case (mck_st_ff)
                st_relock: begin
                    // Lock is back; the master clock still needs settling
                    nxt_mck_st = st_settle;
                    nxt_mck_cnt = mck_cnt_ff - 4'h1;
                end
                st_settle: begin
                    if (mck_cnt_ff != 4'h0) begin
                        nxt_mck_cnt = mck_cnt_ff - 4'h1;
                    end else begin
                        nxt_mck_st = st_ready;
                        nxt_mck_rdy = 1'b1;
                    end
                end
                default: begin
                    nxt_mck_st = st_ready;
                    nxt_mck_rdy = 1'b1;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            css_ff <= `MCS_MCKCFG_RST;
            clock_divider_select_ff <= 3'h0;
            mck_st_ff <= st_ready;
            mck_rdy_ff <= 1'b1;
            mck_cnt_ff <= 4'h0;
            mck_div_ff <= 6'h00;
            master_clk_out <= 1'b0;
            // Track the pins during reset so no false edge follows it
            src_prev_ff <= src_lvl;
        end else begin
            src_prev_ff <= src_lvl;
            if (mck_wr) begin
                css_ff <= pwdata[`MCS_CSS_MSB:`MCS_CSS_LSB];
                clock_divider_select_ff <= pwdata[`MCS_CLOCK_DIVIDER_SELECT_MSB:`MCS_CLOCK_DIVIDER_SELECT_LSB];
            end
            mck_st_ff <= nxt_mck_st;
            mck_rdy_ff <= nxt_mck_rdy;
            mck_cnt_ff <= nxt_mck_cnt;
            if (src_rise[mck_idx])
                mck_div_ff <= mck_div_ff + 6'h01;
            master_clk_out <= div_tap(src_lvl[mck_idx], mck_div_ff,
                                      clock_divider_select_ff);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_syn
            reg lock_ff;
            reg [5:0] cnt_ff;
            reg [13:0] cfg_ff;
            wire syn_wr;
            assign syn_wr = wr_acc &
                (paddr[7:4] == `MCS_OFF_SYN_PAGE) &
                (paddr[3:2] == g) & (paddr[1:0] == 2'h0);
            assign lock_w[g] = lock_ff;
            assign syn_cfg_w[g*14 +: 14] = cfg_ff;
            // [R17] count slow edges to lock
            always @(posedge core_clk) begin
                if (rst) begin
                    lock_ff <= 1'b1;
                    cnt_ff <= 6'h00;
                    cfg_ff <= 14'h0000;
                end else if (syn_wr) begin
                    lock_ff <= 1'b0;
                    cnt_ff <= pwdata[`MCS_SCNT_MSB:`MCS_SCNT_LSB];
                    cfg_ff <= pwdata[13:0];
                end else if (~lock_ff & src_rise[`MCS_PSRC_SLOW]) begin
                    if (cnt_ff == 6'h00)
                        lock_ff <= 1'b1;
                    else
                        cnt_ff <= cnt_ff - 6'h01;
                end
            end
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_pck
            reg en_ff;
            reg rdy_ff;
            reg [3:0] cnt_ff;
            reg [5:0] div_ff;
            reg [5:0] cfg_ff;
            reg out_ff;
            wire [2:0] sel;
            wire ena;
            wire dis;
            wire cfg_wr;
            assign sel = (cfg_ff[2:0] > `MCS_PSRC_SYNB) ? `MCS_PSRC_SLOW
                                                        : cfg_ff[2:0];
            assign ena = wr_acc & (paddr == `MCS_OFF_PENA) & pwdata[i];
            assign dis = wr_acc & (paddr == `MCS_OFF_PDIS) & pwdata[i];
            assign cfg_wr = wr_acc &
                (paddr[7:4] == `MCS_OFF_PCFG_PAGE) &
                (paddr[3:2] == i) & (paddr[1:0] == 2'h0);
            assign pck_en_w[i] = en_ff;
            assign pck_rdy_w[i] = rdy_ff;
            assign pck_cfg_w[i*6 +: 6] = cfg_ff;
            assign prog_clock_out[i] = out_ff;
            always @(posedge core_clk) begin
                // [R10] disabled after reset
                // [R13] prescaler and source reset to zero
                if (rst) begin
                    en_ff <= 1'b0;
                    rdy_ff <= 1'b0;
                    cnt_ff <= 4'h0;
                    div_ff <= 6'h00;
                    cfg_ff <= `MCS_PCFG_RST;
                    out_ff <= 1'b0;
                end else begin
                    // [R15] whole config in one write
                    if (cfg_wr)
                        cfg_ff <= {pwdata[6:4], pwdata[2:0]};
                    // [R9] write-one enable and disable
                    // [R18] disable clears ready
                    if (dis) begin
                        en_ff <= 1'b0;
                        rdy_ff <= 1'b0;
                    end else if (ena & ~en_ff) begin
                        en_ff <= 1'b1;
                        rdy_ff <= 1'b0;
                        cnt_ff <= `MCS_PCK_SETTLE;
                    end else if (en_ff & ~rdy_ff) begin
                        // [R14] ready after settle
                        if (cnt_ff == 4'h0)
                            rdy_ff <= 1'b1;
                        else
                            cnt_ff <= cnt_ff - 4'h1;
                    end
                    // [R11] selected source
                    if (~en_ff)
                        div_ff <= 6'h00;
                    else if (src_rise[sel])
                        div_ff <= div_ff + 6'h01;
                    // [R12] power-of-two divide
                    // [R18] held low until ready
                    out_ff <= rdy_ff & ~dis &
                              div_tap(src_lvl[sel], div_ff, cfg_ff[5:3]);
                end
            end
        end
    endgenerate

    always @* begin
        rd_hit = 1'b1;
        rd_mux = 32'h00000000;
        case (paddr)
            `MCS_OFF_MCKCFG: rd_mux = {25'h0000000, clock_divider_select_ff, 2'h0, css_ff};
            `MCS_OFF_STATUS: rd_mux = status_w;
            `MCS_OFF_IRQSTS: rd_mux = irq_sts_ff;
            `MCS_OFF_IRQEN: rd_mux = irq_en_ff;
            `MCS_OFF_PENA: rd_mux = 32'h00000000;
            `MCS_OFF_PDIS: rd_mux = 32'h00000000;
            `MCS_OFF_PSTATE: rd_mux = {29'h00000000, pck_en_w};
            8'h20: rd_mux = {25'h0000000, pck_cfg_w[5:3], 1'b0,
                             pck_cfg_w[2:0]};
            8'h24: rd_mux = {25'h0000000, pck_cfg_w[11:9], 1'b0,
                             pck_cfg_w[8:6]};
            8'h28: rd_mux = {25'h0000000, pck_cfg_w[17:15], 1'b0,
                             pck_cfg_w[14:12]};
            8'h30: rd_mux = {18'h00000, syn_cfg_w[13:0]};
            8'h34: rd_mux = {18'h00000, syn_cfg_w[27:14]};
            default: rd_hit = 1'b0;
        endcase
    end

    // Event set beats a same-cycle write-one clear
    always @* begin
        nxt_irq_sts = irq_sts_ff;
        nxt_irq_en = irq_en_ff;
        if (wr_acc & (paddr == `MCS_OFF_IRQSTS))
            nxt_irq_sts = irq_sts_ff & ~pwdata;
        if (wr_acc & (paddr == `MCS_OFF_IRQEN))
            nxt_irq_en = pwdata & `MCS_IRQ_BITS;
        // [R6] ready rise is an event
        // [R14] programmable ready rise too
        nxt_irq_sts = nxt_irq_sts | events_w;
    end

    // One wait state keeps every bus output registered
    always @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            irq_sts_ff <= 32'h00000000;
            irq_en_ff <= 32'h00000000;
            // Matches the reset status so no false event follows reset
            st_prev_ff <= `MCS_STATUS_RST;
            irq <= 1'b0;
        end else begin
            pready <= acc_first;
            pslverr <= acc_first & ~rd_hit;
            if (acc_first & ~pwrite)
                prdata <= rd_mux;
            st_prev_ff <= status_w;
            irq_sts_ff <= nxt_irq_sts;
            irq_en_ff <= nxt_irq_en;
            // [R6] masked level interrupt
            irq <= |(nxt_irq_sts & nxt_irq_en);
        end
    end

endmodule // mcs_clock_switch

`default_nettype wire

/* design/mcs_consts.vh */
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// Register byte offsets
`define MCS_OFF_MCKCFG 8'h00
`define MCS_OFF_STATUS 8'h04
`define MCS_OFF_IRQSTS 8'h08
`define MCS_OFF_IRQEN 8'h0C
`define MCS_OFF_PENA 8'h10
`define MCS_OFF_PDIS 8'h14
`define MCS_OFF_PSTATE 8'h18
`define MCS_OFF_PCFG_PAGE 4'h2
`define MCS_OFF_SYN_PAGE 4'h3

// Master clock config fields
`define MCS_CSS_MSB 1
`define MCS_CSS_LSB 0
`define MCS_CLOCK_DIVIDER_SELECT_MSB 6
`define MCS_CLOCK_DIVIDER_SELECT_LSB 4

// Programmable clock config fields
`define MCS_PCSS_MSB 2
`define MCS_PCSS_LSB 0

// Synth config settle count field
`define MCS_SCNT_MSB 13
`define MCS_SCNT_LSB 8

// Status bit positions
`define MCS_ST_LOCK_LSB 1
`define MCS_ST_MAIN_CLK_READY_FLAG 3
`define MCS_ST_PCKRDY_LSB 8
`define MCS_IRQ_BITS 32'h0000070E

// Master source encodings
`define MCS_SRC_SLOW 2'h0
`define MCS_SRC_MAIN 2'h1
`define MCS_SRC_SYNA 2'h2
`define MCS_SRC_SYNB 2'h3

// Programmable source encodings (index into source vector)
`define MCS_PSRC_SLOW 3'h0
`define MCS_PSRC_MAIN 3'h1
`define MCS_PSRC_MCK 3'h2
`define MCS_PSRC_SYNA 3'h3
`define MCS_PSRC_SYNB 3'h4

// Reset values
`define MCS_MCKCFG_RST 2'h0
`define MCS_STATUS_RST 32'h0000000E
`define MCS_PCFG_RST 6'h00

// Settle times in core clock cycles
`define MCS_MCK_SETTLE 4'h4
`define MCS_PCK_SETTLE 4'h2

`endif

/* dv/mcs_clock_switch_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_switch_chk (
    input wire core_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire master_clk_out,
    input wire [2:0] prog_clock_out,
    input wire irq
);
    logic [2:0] ena_ff;
    logic [2:0] ena_q_ff;
    logic [2:0] ena_q2_ff;
    logic [31:0] ien_ff;
    logic [31:0] ien_q_ff;
    wire wr_done = psel && penable && pready && pwrite;
    wire rd_done = psel && penable && pready && !pwrite;
    wire [2:0] ena_any = ena_ff | ena_q_ff | ena_q2_ff;
    wire low_map = paddr[7:5] == 3'h0 && paddr[4:2] != 3'h7;
    wire mid_map = paddr[7:4] == 4'h2 && paddr[3:2] != 2'h3;
    wire high_map = paddr[7:4] == 4'h3 && !paddr[3];
    wire mapped = paddr[1:0] == 2'h0 && (low_map || mid_map || high_map);
    // Delayed copies give slack for the registered output latency
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ena_ff <= 3'h0;
            ien_ff <= 32'h0;
        end else begin
            if (wr_done && paddr == 8'h10)
                ena_ff <= ena_ff | pwdata[2:0];
            else if (wr_done && paddr == 8'h14)
                ena_ff <= ena_ff & ~pwdata[2:0];
            if (wr_done && paddr == 8'h0C)
                ien_ff <= pwdata & 32'h0000070E;
        end
        ena_q_ff <= ena_ff;
        ena_q2_ff <= ena_q_ff;
        ien_q_ff <= ien_ff;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_answer_wait: assert property (psel && !penable |-> ##2 pready)
        else $error("pready not two cycles after setup");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_resp_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    chk_err_unmapped: assert property (pslverr |-> pready && !mapped)
        else $error("pslverr on mapped address");
    chk_state_read:
        assert property (rd_done && paddr == 8'h18 |-> prdata == {29'h0, ena_ff})
        else $error("output state readback wrong");
    chk_off_disabled:
        assert property ((prog_clock_out & ~ena_any) == 3'h0)
        else $error("disabled output not low");
    chk_irq_masked:
        assert property (irq |-> (ien_ff | ien_q_ff) != 32'h0)
        else $error("irq with no source enabled");
    chk_mask_read:
        assert property (rd_done && paddr == 8'h0C |-> prdata == ien_ff)
        else $error("irq enable readback wrong");
    chk_reset_quiet:
        assert property ($fell(rst) |-> !pready && !irq && !master_clk_out
            && prog_clock_out == 3'h0)
        else $error("outputs active after reset");
    cover property (pslverr);
    cover property ($rose(irq));
    cover property ($rose(prog_clock_out[2]));
endmodule // mcs_clock_switch_chk
bind mcs_clock_switch mcs_clock_switch_chk u_chk (.core_clk(core_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .master_clk_out(master_clk_out),
    .prog_clock_out(prog_clock_out), .irq(irq));
`default_nettype wire

/* dv/mcs_clock_switch_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_switch_tb;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic er;} mcs_row_t;
    logic core_clk, rst, psel, penable, pwrite, err;
    logic [7:0] paddr, cnt;
    logic [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire pready, pslverr, master_clk_out, irq;
    wire [2:0] prog_clock_out;
    int failures, comparisons, k;
    mcs_row_t rows [12] = '{
        '{0, 8'h00, 0, 32'h0, 0},
        '{0, 8'h04, 0, 32'hE, 0},
        '{0, 8'h08, 0, 32'h0, 0},
        '{0, 8'h18, 0, 32'h0, 0},
        '{0, 8'h20, 0, 32'h0, 0},
        '{1, 8'h24, 32'h63, 0, 0},
        '{0, 8'h24, 0, 32'h63, 0},
        '{1, 8'h1C, 32'h1, 0, 1},
        '{0, 8'h1C, 0, 32'h0, 1},
        '{1, 8'h0C, 32'hFFFFFFFF, 0, 0},
        '{0, 8'h0C, 0, 32'h70E, 0},
        '{1, 8'h0C, 32'h0, 0, 0}};
    mcs_clock_switch dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slow_clk_lvl(cnt[3]), .main_clk_lvl(cnt[2]),
        .first_synth_output(cnt[1]), .second_synth_output(cnt[4]),
        .master_clk_out(master_clk_out), .prog_clock_out(prog_clock_out),
        .irq(irq));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // Source clocks stay well below half the core rate so they are seen
    always @(posedge core_clk) cnt <= cnt + 8'h01;
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", 1'b1, pready);
        if (pready !== 1'b1)
            tally_and_finish();
        @(posedge core_clk);
    endtask
    task automatic poll(input logic [31:0] m, v);
        k = 0;
        do begin
            apb(0, 8'h04, 0);
            k++;
        end while ((rd & m) !== v && k < 100);
        chk("status poll", v, rd & m);
        if ((rd & m) !== v)
            tally_and_finish();
    endtask
    task automatic settle_irq(input logic exp);
        repeat (2) @(posedge core_clk);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
        @(posedge core_clk);
    endtask
    // Counts level changes over 64 edges; s 0 is master, 1..3 outputs
    task automatic toggles(input int s, input logic [31:0] n);
        logic [3:0] v;
        logic p;
        int t;
        t = 0;
        #1;
        v = {prog_clock_out, master_clk_out};
        p = v[s];
        repeat (64) begin
            @(posedge core_clk);
            #1;
            v = {prog_clock_out, master_clk_out};
            if (v[s] !== p)
                t++;
            p = v[s];
        end
        chk($sformatf("toggles %0d", s), n, t);
        @(posedge core_clk);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
    endtask
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, cnt} = '0;
        failures = 0;
        comparisons = 0;
        do_reset();
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w)
                chk($sformatf("read %h", rows[i].a), rows[i].e, rd);
            chk($sformatf("pslverr %h", rows[i].a), rows[i].er, err);
        end
        apb(1, 8'h08, 32'hFFFFFFFF);
        apb(1, 8'h00, 32'h1);
        apb(0, 8'h04, 0);
        chk("ready drop", 32'h6, rd & 32'h70E);
        poll(32'h8, 32'h8);
        apb(1, 8'h00, 32'h11);
        poll(32'h8, 32'h8);
        toggles(0, 8);
        settle_irq(1'b0);
        apb(1, 8'h0C, 32'h8);
        settle_irq(1'b1);
        apb(1, 8'h08, 32'h8);
        settle_irq(1'b0);
        apb(1, 8'h0C, 32'h0);
        apb(1, 8'h00, 32'h13);
        poll(32'h8, 32'h8);
        toggles(0, 2);
        apb(1, 8'h34, 32'h800);
        apb(0, 8'h04, 0);
        chk("relock", 32'h2, rd & 32'hE);
        toggles(0, 8);
        poll(32'hE, 32'hE);
        toggles(0, 2);
        apb(1, 8'h28, 32'h11);
        apb(1, 8'h10, 32'h4);
        poll(32'h400, 32'h400);
        toggles(3, 8);
        apb(1, 8'h14, 32'h4);
        apb(0, 8'h04, 0);
        chk("ready cleared", 32'h0, rd & 32'h400);
        chk("disabled out", 32'h0, {29'h0, prog_clock_out});
        toggles(3, 0);
        apb(1, 8'h10, 32'h1);
        poll(32'h100, 32'h100);
        toggles(1, 8);
        do_reset();
        apb(0, 8'h18, 0);
        chk("state after reset", 32'h0, rd);
        apb(0, 8'h08, 0);
        chk("irq status after reset", 32'h0, rd);
        tally_and_finish();
    end
endmodule // mcs_clock_switch_tb
`default_nettype wire
